//--- verilog/eeprom_wp_link.sv
// package of shared constants and the serial-clock frame capture module
`timescale 1ns/1ps

// ==========================================================
// shared constants
package eeprom_wp_pkg;
    localparam logic [7:0] CMD_ARRAY_WRITE = 8'h02;
    localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
    localparam int STATUS_PIN_ENABLE_POS = 7;
    localparam int STATUS_BP_HI_POS = 3;
    localparam int STATUS_BP_LO_POS = 2;
    localparam logic [11:0] BITS_COMMAND = 12'h008;
    localparam logic [11:0] BITS_STATUS_FRAME = 12'h010;
    localparam logic [11:0] BITS_HEADER = 12'h018;
    localparam logic [11:0] BITS_MIN_WRITE = 12'h020;
    localparam logic [11:0] BITS_MAX = 12'h0fff;
    localparam int ADDR_WIDTH = 10;
    localparam logic [9:0] UPPER_QUARTER_BASE = 10'h300;
    localparam logic [9:0] UPPER_HALF_BASE = 10'h200;
    localparam logic [1:0] BP_NONE = 2'h0;
    localparam logic [1:0] BP_QUARTER = 2'h1;
    localparam logic [1:0] BP_HALF = 2'h2;
    localparam logic [1:0] BP_ALL = 2'h3;
    localparam logic [4:0] PAGE_BYTES = 5'h10;
    localparam logic LATCH_RESET = 1'b0;
    localparam logic PIN_ENABLE_INIT = 1'b0;
    localparam logic [1:0] BP_INIT = 2'h0;
    localparam int CLK_PERIOD_NS = 20;
    localparam int WRITE_CYCLE_NS = 5000000;
    localparam int WRITE_CYCLE_CYCLES = WRITE_CYCLE_NS / CLK_PERIOD_NS;
endpackage

// ==========================================================
// frame capture on the serial clock
module eeprom_wp_link (
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    output logic [11:0] bit_count,
    output logic [23:0] shift_word
);
    logic in_frame;

    // chip select high clears only this flag, so count and word survive
    // the frame end for the system side to read while sck stands still
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            in_frame <= 1'b0;
        end else begin
            in_frame <= 1'b1;
        end
    end

    always_ff @(posedge sck) begin
        if (!in_frame) begin
            bit_count <= 12'h001;
        end else if (bit_count != eeprom_wp_pkg::BITS_MAX) begin
            bit_count <= bit_count + 12'h001;
        end
    end

    // msb first, sampled on the rising edge; frozen once the header is in
    always_ff @(posedge sck) begin
        if (!in_frame) begin
            shift_word <= {23'h00_0000, si};
        end else if (bit_count < eeprom_wp_pkg::BITS_HEADER) begin
            shift_word <= {shift_word[22:0], si};
        end
    end
endmodule

//--- verilog/eeprom_wp_ctrl.sv
// write-enable latch, block protection and status write control
`timescale 1ns/1ps

// ==========================================================
// Operation
// - status write selects one of four levels
// - 00 none, 01 top quarter, 10 half, 11 all
// - pin enable bit is nonvolatile, gates pin
// - hardware protect needs pin low and enable
// - pin high or enable zero: no protect
// - hardware protect blocks only status writes
// - write-enable latch clear after power-up
// - only write-enable command sets the latch
// - finished write clears write-enable latch
// - write starts only on exact-count select rise
// - accesses during internal write are ignored
// - power-up standby, select high, output off
// - select falling edge needed to become active
// - latch clear refuses every write
// - latch, enable, pin low: status refused
// - latch and no hardware protect: status writable
// - latch set only on rise after eight bits
// - enable command sets, disable command clears
// - msb first, sampled on rising clock
module eeprom_wp_ctrl #(
    parameter int WRITE_CYCLE_CYCLES = eeprom_wp_pkg::WRITE_CYCLE_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic wp_n,
    output logic so,
    output logic so_oe,
    output logic write_enable_latch_flag,
    output logic write_in_progress,
    output logic protect_pin_enable_bit,
    output logic block_protect_hi,
    output logic block_protect_lo,
    output logic hw_protect_active,
    output logic device_active,
    output logic array_write_start,
    output logic [9:0] array_write_addr,
    output logic [4:0] array_write_bytes,
    output logic array_write_refused,
    output logic status_write_refused
);
    localparam int TW = $clog2(WRITE_CYCLE_CYCLES + 1);

    typedef enum logic [1:0] {IDLE, BUSY_ARRAY, BUSY_STATUS} wr_state_t;

    logic [11:0] bit_count;
    logic [23:0] shift_word;
    logic cs_meta;
    logic cs_sync;
    logic cs_prev;
    logic wp_meta;
    logic wp_sync;
    logic frame_end;
    logic frame_start;
    logic frame_ok;
    logic [7:0] cmd;
    logic [1:0] bp;
    logic status_locked;
    logic is_enable_cmd;
    logic is_disable_cmd;
    logic is_status_cmd;
    logic is_write;
    logic array_ok;
    logic status_ok;
    logic [9:0] frame_addr;
    logic [11:0] data_bits;
    logic [4:0] next_bytes;
    logic pend_pin_enable;
    logic [1:0] pend_bp;
    logic [TW-1:0] timer;
    logic timer_done;
    wr_state_t state;

    // ==========================================================
    // serial side
    eeprom_wp_link u_eeprom_wp_link (
        .sck(sck),
        .cs_n(cs_n),
        .si(si),
        .bit_count(bit_count),
        .shift_word(shift_word)
    );

    // ==========================================================
    // pin synchronisers
    // select resets high so the device starts deselected
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cs_meta <= 1'b1;
            cs_sync <= 1'b1;
            cs_prev <= 1'b1;
            wp_meta <= 1'b1;
            wp_sync <= 1'b1;
        end else begin
            cs_meta <= cs_n;
            cs_sync <= cs_meta;
            cs_prev <= cs_sync;
            wp_meta <= wp_n;
            wp_sync <= wp_meta;
        end
    end

    // link words are quiet by the time the synced rise is seen
    assign frame_end = cs_sync & ~cs_prev;
    assign frame_start = ~cs_sync & cs_prev;

    // ==========================================================
    // standby and activation
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            device_active <= 1'b0;
        end else if (frame_start) begin
            device_active <= 1'b1;
        end
    end

    // no read path here, the output never drives
    assign so = 1'b0;
    assign so_oe = 1'b0;

    // ==========================================================
    // frame decode
    function automatic logic [7:0] cmd_of(input logic [11:0] n, input logic [23:0] w);
        if (n == eeprom_wp_pkg::BITS_COMMAND) begin
            cmd_of = w[7:0];
        end else if (n == eeprom_wp_pkg::BITS_STATUS_FRAME) begin
            cmd_of = w[15:8];
        end else if (n >= eeprom_wp_pkg::BITS_HEADER) begin
            cmd_of = w[23:16];
        end else begin
            cmd_of = 8'h00;
        end
    endfunction

    function automatic logic addr_protected(input logic [1:0] b, input logic [9:0] a);
        case (b)
            eeprom_wp_pkg::BP_NONE: addr_protected = 1'b0;
            eeprom_wp_pkg::BP_QUARTER: addr_protected = a >= eeprom_wp_pkg::UPPER_QUARTER_BASE;
            eeprom_wp_pkg::BP_HALF: addr_protected = a >= eeprom_wp_pkg::UPPER_HALF_BASE;
            eeprom_wp_pkg::BP_ALL: addr_protected = 1'b1;
            default: addr_protected = 1'b1;
        endcase
    endfunction

    assign bp = {block_protect_hi, block_protect_lo};
    assign cmd = cmd_of(bit_count, shift_word);
    assign frame_addr = shift_word[9:0];
    assign data_bits = bit_count - eeprom_wp_pkg::BITS_HEADER;
    // busy or standby: the frame is dropped and programming carries on
    assign frame_ok = frame_end & device_active & (state == IDLE);
    assign is_enable_cmd = frame_ok & (cmd == eeprom_wp_pkg::CMD_WRITE_ENABLE)
        & (bit_count == eeprom_wp_pkg::BITS_COMMAND);
    assign is_disable_cmd = frame_ok & (cmd == eeprom_wp_pkg::CMD_WRITE_DISABLE)
        & (bit_count == eeprom_wp_pkg::BITS_COMMAND);
    assign is_status_cmd = frame_ok & (cmd == eeprom_wp_pkg::CMD_STATUS_WRITE)
        & (bit_count == eeprom_wp_pkg::BITS_STATUS_FRAME);
    // a write must end exactly on a byte boundary after at least one byte
    assign is_write = frame_ok & (cmd == eeprom_wp_pkg::CMD_ARRAY_WRITE)
        & (bit_count >= eeprom_wp_pkg::BITS_MIN_WRITE)
        & (bit_count[2:0] == 3'h0);

    // ==========================================================
    // protection matrix
    assign hw_protect_active = protect_pin_enable_bit & ~wp_sync;
    assign status_locked = ~write_enable_latch_flag | hw_protect_active;
    assign status_ok = is_status_cmd & ~status_locked;
    assign array_ok = is_write & write_enable_latch_flag
        & ~addr_protected(bp, frame_addr);

    // pages roll over, so a longer stream still programs one page
    always_comb begin
        if (data_bits[11:3] >= 9'(eeprom_wp_pkg::PAGE_BYTES)) begin
            next_bytes = eeprom_wp_pkg::PAGE_BYTES;
        end else begin
            next_bytes = data_bits[7:3];
        end
    end

    // ==========================================================
    // internal write cycle
    assign timer_done = (timer == TW'(WRITE_CYCLE_CYCLES - 1));

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state <= IDLE;
        end else begin
            case (state)
                IDLE: begin
                    if (status_ok) begin
                        state <= BUSY_STATUS;
                    end else if (array_ok) begin
                        state <= BUSY_ARRAY;
                    end
                end
                BUSY_ARRAY, BUSY_STATUS: begin
                    if (timer_done) begin
                        state <= IDLE;
                    end
                end
                default: state <= IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n || state == IDLE) begin
            timer <= '0;
        end else begin
            timer <= timer + TW'(1);
        end
    end

    assign write_in_progress = (state != IDLE);

    // ==========================================================
    // write-enable latch
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            write_enable_latch_flag <= eeprom_wp_pkg::LATCH_RESET;
        end else if (write_in_progress && timer_done) begin
            write_enable_latch_flag <= 1'b0;
        end else if (is_enable_cmd) begin
            write_enable_latch_flag <= 1'b1;
        end else if (is_disable_cmd) begin
            write_enable_latch_flag <= 1'b0;
        end
    end

    // ==========================================================
    // nonvolatile status bits
    // kept out of the reset so they outlive it, like the cells they model
    logic nv_pin_enable = eeprom_wp_pkg::PIN_ENABLE_INIT;
    logic [1:0] nv_bp = eeprom_wp_pkg::BP_INIT;

    assign protect_pin_enable_bit = nv_pin_enable;
    assign block_protect_hi = nv_bp[1];
    assign block_protect_lo = nv_bp[0];

    always_ff @(posedge clk_sys) begin
        if (status_ok) begin
            pend_pin_enable <= shift_word[eeprom_wp_pkg::STATUS_PIN_ENABLE_POS];
            pend_bp <= {shift_word[eeprom_wp_pkg::STATUS_BP_HI_POS],
                shift_word[eeprom_wp_pkg::STATUS_BP_LO_POS]};
        end
    end

    // new values appear when the internal cycle completes
    always_ff @(posedge clk_sys) begin
        if (state == BUSY_STATUS && timer_done) begin
            nv_pin_enable <= pend_pin_enable;
            nv_bp <= pend_bp;
        end
    end

    // ==========================================================
    // array write request and refusals
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            array_write_start <= 1'b0;
            array_write_addr <= '0;
            array_write_bytes <= '0;
            array_write_refused <= 1'b0;
            status_write_refused <= 1'b0;
        end else begin
            array_write_start <= array_ok & ~status_ok;
            array_write_refused <= is_write & ~array_ok;
            status_write_refused <= is_status_cmd & status_locked;
            if (array_ok) begin
                array_write_addr <= frame_addr;
                array_write_bytes <= next_bytes;
            end
        end
    end

    // ==========================================================
    // checks
    chk_latch_set_enable: assert property (@(posedge clk_sys) disable iff (!rst_n)
        is_enable_cmd |=> write_enable_latch_flag)
        else $error("latch not set by enable command");

    chk_latch_clear_disable: assert property (@(posedge clk_sys) disable iff (!rst_n)
        is_disable_cmd |=> !write_enable_latch_flag)
        else $error("latch not cleared by disable command");

    chk_latch_clear_done: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $fell(write_in_progress) |-> !write_enable_latch_flag)
        else $error("latch survived finished write");

    chk_locked_status_refused: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (is_status_cmd && status_locked) |=> (status_write_refused && !write_in_progress))
        else $error("locked status write was taken");

    chk_status_bits_settle: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ($changed(bp) || $changed(protect_pin_enable_bit)) |-> $past(write_in_progress))
        else $error("status bits changed outside a status write");

    chk_protected_addr: assert property (@(posedge clk_sys) disable iff (!rst_n)
        array_write_start |-> !addr_protected(bp, array_write_addr))
        else $error("write started into a protected block");

    chk_start_needs_wel: assert property (@(posedge clk_sys) disable iff (!rst_n)
        array_write_start |-> ($past(write_enable_latch_flag) && $past(!write_in_progress)))
        else $error("array write without latch or while busy");

    chk_busy_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(write_in_progress) |-> write_in_progress [*8])
        else $error("internal write cycle cut short");

    chk_standby_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !device_active |-> (!write_enable_latch_flag && !write_in_progress))
        else $error("activity before select fell");

    chk_output_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !so_oe)
        else $error("serial output driven");

    chk_status_hw_locked: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (is_status_cmd && hw_protect_active) |=> status_write_refused)
        else $error("status write taken under hardware protect");

    chk_status_taken: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (is_status_cmd && !status_locked) |=> (write_in_progress && !status_write_refused))
        else $error("open status write not started");

    chk_activate_on_fall: assert property (@(posedge clk_sys) disable iff (!rst_n)
        frame_start |=> device_active)
        else $error("select fall did not wake device");

    chk_page_bytes: assert property (@(posedge clk_sys) disable iff (!rst_n)
        array_write_start |-> (array_write_bytes != 5'h00
            && array_write_bytes <= eeprom_wp_pkg::PAGE_BYTES))
        else $error("write byte count out of range");
endmodule

//--- bench/spi_host_model.sv
// serial host model driving select, serial clock and data
`timescale 1ns/1ps

// ==========================================
// host side of the serial link
module spi_host_model (
    output logic sck,
    output logic cs_n,
    output logic si
);
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b1;
    end
    // link clock runs only inside a frame; 160 ns period, phase free of clk_sys
    task automatic xfer(input logic [47:0] w, input int n);
        #217;
        cs_n = 1'b0; // a falling select wakes the device
        #80;
        for (int i = n - 1; i >= 0; i--) begin
            si = w[i]; // msb first, held across the rising edge
            #80;
            sck = 1'b1;
            #80;
            sck = 1'b0;
        end
        #80;
        cs_n = 1'b1; // rise 80 ns after the last falling clock edge
        si = ~si; // released line must not show a stale value
    endtask
endmodule

//--- bench/eeprom_write_protect_control_test.sv
// self-checking bench for the write-protect control block
`timescale 1ns/1ps

// ==========================================
// bench top
module eeprom_write_protect_control_test;
    // long enough that a whole frame fits inside one internal write
    localparam int WCYC = 400;
    localparam logic [7:0] WEN = eeprom_wp_pkg::CMD_WRITE_ENABLE;
    localparam logic [7:0] WDI = eeprom_wp_pkg::CMD_WRITE_DISABLE;
    localparam logic [7:0] AWR = eeprom_wp_pkg::CMD_ARRAY_WRITE;
    localparam logic [7:0] SWR = eeprom_wp_pkg::CMD_STATUS_WRITE;
    logic clk_sys, rst_n, wp_n, sck, cs_n, si, so, so_oe, latch, wip, pen, bph, bpl;
    logic hwp, act, aws, awr, swr;
    logic [9:0] awa;
    logic [4:0] awb;
    int n_errors = 0;
    int compares = 0;

    spi_host_model u_spi_host_model (.sck(sck), .cs_n(cs_n), .si(si));
    eeprom_wp_ctrl #(.WRITE_CYCLE_CYCLES(WCYC)) u_eeprom_wp_ctrl (
        .clk_sys(clk_sys), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .si(si), .wp_n(wp_n),
        .so(so), .so_oe(so_oe), .write_enable_latch_flag(latch), .write_in_progress(wip),
        .protect_pin_enable_bit(pen), .block_protect_hi(bph), .block_protect_lo(bpl),
        .hw_protect_active(hwp), .device_active(act), .array_write_start(aws),
        .array_write_addr(awa), .array_write_bytes(awb), .array_write_refused(awr),
        .status_write_refused(swr));

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // ==========================================
    // shared helpers
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    function automatic logic prot(input logic [1:0] bp, input logic [9:0] a);
        return bp == eeprom_wp_pkg::BP_ALL ||
            (bp == eeprom_wp_pkg::BP_HALF && a >= eeprom_wp_pkg::UPPER_HALF_BASE) ||
            (bp == eeprom_wp_pkg::BP_QUARTER && a >= eeprom_wp_pkg::UPPER_QUARTER_BASE);
    endfunction
    // expected pulse set is {start, array refused, status refused}
    task automatic frame(input logic [47:0] w, input int n, input logic [2:0] exp);
        logic [2:0] seen;
        logic [47:0] t;
        seen = 3'h0;
        t = w >> (n - 24);
        u_spi_host_model.xfer(w, n);
        repeat (12) begin
            @(posedge clk_sys);
            #1;
            seen = seen | {aws, awr, swr};
            if (aws === 1'b1) begin
                check("addr", 16'(awa), 16'(t[9:0]));
                check("bytes", 16'(awb), 16'((n - 24) / 8));
            end
        end
        check("pulses", 16'(seen), 16'(exp));
    endtask
    task automatic wait_idle();
        int k;
        k = 0;
        while (wip !== 1'b0 && k < 1000) begin
            @(posedge clk_sys);
            k++;
        end
        if (k == 1000) begin
            n_errors++;
            $display("[ERR] busy wait ran out");
            summarize();
        end
    endtask
    task automatic enable_writes();
        frame(48'(WEN), 8, 3'h0);
        check("latch set", 16'(latch), 16'h0001);
    endtask
    task automatic set_status(input logic [7:0] d, input logic ok);
        enable_writes();
        frame(48'({SWR, d}), 16, ok ? 3'h0 : 3'h1);
        wait_idle();
        if (ok) begin
            check("status", 16'({pen, bph, bpl, latch}), 16'({d[7], d[3], d[2], 1'b0}));
        end
    endtask
    task automatic write_at(input logic [9:0] a, input logic p);
        enable_writes();
        frame(48'({AWR, 6'h00, a, 8'hA5}), 32, p ? 3'h2 : 3'h4);
        wait_idle();
        check("latch after", 16'(latch), 16'(p));
    endtask

    // ==========================================
    // scenarios
    task automatic scen_latch_rules();
        frame(48'({AWR, 16'h0010, 8'h11}), 32, 3'h2);
        check("awake", 16'(act), 16'h0001);
        frame(48'({SWR, 8'h8C}), 16, 3'h1);
        frame({8'h00, WEN, AWR, 16'h0000, 8'hA5}, 40, 3'h0);
        check("no latch", 16'(latch), 16'h0000);
        enable_writes();
        frame(48'({AWR, 16'h0010, 8'h11, 1'b1}), 33, 3'h0);
        check("odd count", 16'({latch, wip}), 16'h0002);
        frame(48'(WDI), 8, 3'h0);
        check("latch clear", 16'(latch), 16'h0000);
    endtask
    task automatic scen_block_levels();
        logic [9:0] addrs [6];
        addrs = '{10'h000, 10'h1FF, 10'h200, 10'h2FF, 10'h300, 10'h3FF};
        for (int b = 0; b < 4; b++) begin
            set_status({4'h0, 2'(b), 2'h0}, 1'b1);
            foreach (addrs[i]) write_at(addrs[i], prot(2'(b), addrs[i]));
        end
        set_status(8'h00, 1'b1);
    endtask
    task automatic scen_hw_protect();
        set_status(8'h80, 1'b1);
        wp_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        check("hw on", 16'(hwp), 16'h0001);
        set_status(8'h0C, 1'b0);
        check("kept", 16'({pen, bph, bpl, wip, latch}), 16'h0011);
        write_at(10'h100, 1'b0);
        @(posedge clk_sys);
        wp_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        check("hw off", 16'(hwp), 16'h0000);
        set_status(8'h00, 1'b1);
        @(posedge clk_sys);
        wp_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        check("hw no en", 16'(hwp), 16'h0000);
        @(posedge clk_sys);
        wp_n <= 1'b1;
    endtask
    task automatic scen_busy();
        enable_writes();
        frame({AWR, 16'h0010, 16'h1122}, 40, 3'h4);
        frame(48'({AWR, 16'h0020, 8'h33}), 32, 3'h0);
        check("still busy", 16'(wip), 16'h0001);
        wait_idle();
        check("latch done", 16'(latch), 16'h0000);
    endtask
    task automatic do_reset();
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        check("power up", 16'({latch, wip, act, so_oe, so}), 16'h0000);
    endtask

    initial begin
        rst_n = 1'b0;
        wp_n = 1'b1;
        do_reset();
        check("nv init", 16'({pen, bph, bpl}), 16'h0000);
        scen_latch_rules();
        scen_block_levels();
        scen_hw_protect();
        scen_busy();
        set_status(8'h88, 1'b1);
        do_reset();
        check("nv kept", 16'({pen, bph, bpl}), 16'h0006);
        set_status(8'h00, 1'b1);
        summarize();
    end
endmodule
